// File: dv/dma_fifo_status_flags_bench.sv
`timescale 1ns/10ps
`include "dsf_consts.svh"
module dma_fifo_status_flags_bench;
  import dsf_pkg::*;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, push, pop, hold, er;
  logic        last_done = 1'b0, scsi_byte = 1'b0, perr = 1'b0;
  logic        fill = 1'b0, drain = 1'b0, slow = 1'b0, pop_chk = 1'b0;
  logic [7:0]  push_data, pop_data, exp_pop;
  logic [7:0]  q[$];
  dsf_status_t st;
  int          n_mismatch = 0, checks_done = 0, cyc = 0, n;
  int          thr = `DSF_THR_LVL0, cls = `DSF_CLS_LVL0;

  always #50 clk_i = ~clk_i;

  dsf_top DUT (.clk_i, .nrst_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .dma_push_i(push), .dma_push_data_i(push_data), .dma_pop_i(pop),
    .dma_pop_data_o(pop_data), .dma_hold_o(hold), .dma_last_done_i(last_done),
    .scsi_byte_i(scsi_byte), .parity_err_i(perr), .status_o(st));
  dsf_host_dma_model u_dma (.clk_i, .fill_i(fill), .drain_i(drain), .slow_i(slow),
    .push_o(push), .data_o(push_data), .pop_o(pop));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // fifo mirror and random side traffic
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (pop_chk) chk("pop_data", {24'h0, exp_pop}, {24'h0, pop_data});
    pop_chk <= 1'b0;
    if (push && !hold && q.size() < 256) q.push_back(push_data);
    if (pop && !hold && q.size() > 0) begin
      exp_pop <= q.pop_front();
      pop_chk <= 1'b1;
    end
    slow <= ($urandom_range(0, 3) == 0);
    scsi_byte <= 1'($urandom_range(0, 1));
  end

  always @(posedge clk_i) if (cyc > 20000) begin
    n_mismatch++;
    final_report();
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // firmware-style gap between a control write and the dependent read
  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask : settle

  task automatic lvl_chk;
    int s;
    settle();
    s = q.size();
    apb(1'b0, `DSF_OFF_LEVEL, 32'h0);
    chk("level", 32'(s), rd);
    chk("flags", {27'h0, s == 256, s == 0, s >= thr, s >= cls, s < 8},
      {27'h0, st.fifo_at_capacity, st.fifo_drained, st.data_threshold_flag,
       st.cache_line_flag, st.double_word_empty});
  endtask : lvl_chk

  task automatic run(input logic f, input int target);
    int k;
    fill <= f;
    drain <= !f;
    k = 0;
    while ((f ? q.size() < target : q.size() > target) && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    repeat (4) @(posedge clk_i);
    fill <= 1'b0;
    drain <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : run

  task automatic perr_pulse;
    @(posedge clk_i);
    perr <= 1'b1;
    @(posedge clk_i);
    perr <= 1'b0;
    settle();
  endtask : perr_pulse

  initial begin
    void'($urandom(32'hF6669E10));
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("reset_status", 32'h000040D8, 32'(st));
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped_err", 32'h1, 32'(er));
    chk("unmapped_rd", 32'h0, rd);
    for (int b = 2; b <= 5; b++) begin
      apb(1'b1, `DSF_OFF_FIFO_CTRL, 32'h1 << b);
      settle();
      chk("ctrl_ack", 32'h1, 32'(st[b + 7]));
      apb(1'b1, `DSF_OFF_FIFO_CTRL, 32'h0);
      settle();
      chk("dir_ack", 32'h0, 32'(st.xfer_dir_ack));
    end
    apb(1'b1, `DSF_OFF_FIFO_CTRL, 32'h1 << `DSF_BIT_FIFO_CLEAR);
    settle();
    chk("clear_status", 32'h000040D8, 32'(st));
    q.delete();
    n = $urandom_range(20, 60);
    run(1'b1, n);
    lvl_chk();
    apb(1'b1, `DSF_OFF_CONFIG, 32'h05);
    thr = `DSF_THR_LVL1;
    cls = `DSF_CLS_LVL1;
    apb(1'b0, `DSF_OFF_DATA_PORT, 32'h0);
    chk("port_rd", 32'(q.pop_front()), rd);
    lvl_chk();
    n = $urandom_range(0, 255);
    apb(1'b1, `DSF_OFF_DATA_PORT, 32'(n));
    q.push_back(8'(n));
    chk("port_wr_err", 32'h0, 32'(er));
    run(1'b1, 256);
    lvl_chk();
    apb(1'b1, `DSF_OFF_DATA_PORT, 32'h5A);
    chk("full_wr_err", 32'h1, 32'(er));
    run(1'b0, 0);
    lvl_chk();
    apb(1'b0, `DSF_OFF_DATA_PORT, 32'h0);
    chk("empty_rd_err", 32'h1, 32'(er));
    perr_pulse();
    chk("perr_off", 32'h0, 32'(st.bus_parity_error_flag));
    apb(1'b1, `DSF_OFF_XFER_CTRL1, 32'h1 << `DSF_BIT_PCHK_EN);
    perr_pulse();
    chk("perr_on", 32'h1, 32'(st.bus_parity_error_flag));
    apb(1'b1, `DSF_OFF_INT_CLR1, 32'h1 << `DSF_BIT_PERR_CLR);
    settle();
    chk("perr_clr", 32'h0, 32'(st.bus_parity_error_flag));
    last_done <= 1'b1;
    apb(1'b1, `DSF_OFF_HOST_CNT, 32'h0);
    settle();
    chk("host_done", 32'h1, 32'(st.host_side_done));
    last_done <= 1'b0;
    apb(1'b1, `DSF_OFF_HOST_CNT, 32'h5);
    apb(1'b1, `DSF_OFF_SCSI_CNT, 32'h3);
    settle();
    chk("host_done_load", 32'h0, 32'(st.host_side_done));
    chk("all_done", 32'h0, 32'(st.transfer_all_done));
    chk("scsi_done_load", 32'h0, 32'(st.scsi_side_done));
    apb(1'b1, `DSF_OFF_FIFO_CTRL, 32'h08);
    run(1'b1, 256);
    chk("mreq_full", 32'h1, 32'(st.memory_request_pending));
    apb(1'b1, `DSF_OFF_FIFO_CTRL, 32'h09);
    q.delete();
    settle();
    chk("mreq_clr", 32'h0, 32'(st.memory_request_pending));
    apb(1'b1, `DSF_OFF_FIFO_CTRL, 32'h0A);
    settle();
    chk("flush_ack", 32'h1, 32'(st.flush_ack));
    final_report();
  end
endmodule : dma_fifo_status_flags_bench

// File: dv/dsf_host_dma_model.sv
`timescale 1ns/10ps
module dsf_host_dma_model (
  // clock
  input  wire logic       clk_i,
  // bench commands
  input  wire logic       fill_i,
  input  wire logic       drain_i,
  input  wire logic       slow_i,
  // device side
  output logic            push_o,
  output logic [7:0]      data_o,
  output logic            pop_o
);
  logic [7:0] cnt = 8'h00;
  initial begin
    push_o = 1'b0;
    pop_o = 1'b0;
    data_o = 8'h00;
  end
  // idle data shows the inverse, so a stale byte never passes for a fresh one
  always @(posedge clk_i) begin
    push_o <= fill_i && !slow_i;
    pop_o  <= drain_i && !slow_i;
    cnt    <= cnt + 8'h01;
    data_o <= (fill_i && !slow_i) ? cnt : ~data_o;
  end
endmodule : dsf_host_dma_model

// File: dv/dsf_top_assertions.sv
`timescale 1ns/10ps
`include "dsf_consts.svh"
module dsf_top_assertions
  import dsf_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        nrst_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  // device side
  input wire logic        parity_err_i,
  input wire logic        dma_hold_o,
  input wire dsf_status_t status_o
);
  logic wr;
  logic ctl_wr;
  assign wr = psel_i && penable_i && pready_o && pwrite_i;
  assign ctl_wr = wr && paddr_i == `DSF_OFF_FIFO_CTRL;

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  apb_one_wait_a: assert property (psel_i && $rose(penable_i) |=> pready_o)
    else $error("pready not one cycle after access start");
  bus_ack_a: assert property (
    ctl_wr && pwdata_i[`DSF_BIT_BUS_EN] |-> ##2 status_o.bus_enable_ack)
    else $error("bus enable ack missing");
  host_ack_a: assert property (
    ctl_wr && pwdata_i[`DSF_BIT_HOST_DMA_EN] |-> ##2 status_o.host_dma_enable_ack)
    else $error("host dma enable ack missing");
  dir_follow_a: assert property (ctl_wr && pwdata_i[5:3] == 3'h0 |-> ##2
    status_o.xfer_dir_ack == $past(pwdata_i[`DSF_BIT_DIR], 2))
    else $error("direction ack did not follow");
  dir_cause_a: assert property ($changed(status_o.xfer_dir_ack) |-> $past(ctl_wr, 2))
    else $error("direction ack moved without a control write");
  perr_clear_a: assert property (wr && paddr_i == `DSF_OFF_INT_CLR1 &&
    pwdata_i[`DSF_BIT_PERR_CLR] && !parity_err_i |=> !status_o.bus_parity_error_flag)
    else $error("parity flag not cleared");
  all_done_a: assert property (status_o.transfer_all_done ==
    $past(status_o.host_side_done && status_o.scsi_side_done))
    else $error("overall done is not host and bus done");
  clear_flags_a: assert property (ctl_wr && pwdata_i[`DSF_BIT_FIFO_CLEAR] |=>
    status_o.fifo_at_capacity && status_o.fifo_drained && status_o.double_word_empty)
    else $error("fifo clear did not set level flags");
  clear_mreq_a: assert property (
    ctl_wr && pwdata_i[`DSF_BIT_FIFO_CLEAR] |=> !status_o.memory_request_pending)
    else $error("request pending survived fifo clear");
  hold_window_a: assert property (
    dma_hold_o |-> pready_o && paddr_i == `DSF_OFF_DATA_PORT)
    else $error("dma hold outside a data port commit");

  cover property (ctl_wr && pwdata_i[`DSF_BIT_FIFO_CLEAR]);
  cover property (status_o.fifo_at_capacity && !status_o.fifo_drained);
  cover property (status_o.bus_parity_error_flag);
endmodule : dsf_top_assertions

bind dsf_top dsf_top_assertions u_chk (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pready_o, .parity_err_i, .dma_hold_o, .status_o);

// File: logic/dsf_consts.svh
`ifndef DSF_CONSTS_SVH
`define DSF_CONSTS_SVH

// register offsets (byte addresses)
`define DSF_OFF_FIFO_CTRL   8'h00
`define DSF_OFF_XFER_CTRL1  8'h04
`define DSF_OFF_INT_CLR1    8'h08
`define DSF_OFF_CONFIG      8'h0C
`define DSF_OFF_SCSI_CNT    8'h10
`define DSF_OFF_HOST_CNT    8'h14
`define DSF_OFF_DATA_PORT   8'h18
`define DSF_OFF_STATUS      8'h1C
`define DSF_OFF_LEVEL       8'h20

// fifo_control_reg bits
`define DSF_BIT_BUS_EN      5
`define DSF_BIT_BUS_DMA_EN  4
`define DSF_BIT_HOST_DMA_EN 3
`define DSF_BIT_DIR         2
`define DSF_BIT_FLUSH       1
`define DSF_BIT_FIFO_CLEAR  0
// transfer_control_one bits
`define DSF_BIT_PCHK_EN     5
`define DSF_BIT_WRAP_EN     0
// interrupt_clear_one bits
`define DSF_BIT_PERR_CLR    2
// config bits
`define DSF_BIT_CTH_MODE    4
`define DSF_THR_SEL_LSB     0
`define DSF_CLS_SEL_LSB     2

// reset values
`define DSF_RST_CTRL        5'h00
`define DSF_RST_CONFIG      5'h00

// levels in bytes
`define DSF_FIFO_DEPTH      9'h100
`define DSF_DWORD_EMPTY_LVL 9'h008
`define DSF_QWORD_EMPTY_LVL 9'h008
`define DSF_THR_LVL0        9'h040
`define DSF_THR_LVL1        9'h080
`define DSF_THR_LVL2        9'h0C0
`define DSF_THR_LVL3        9'h100
`define DSF_CLS_LVL0        9'h010
`define DSF_CLS_LVL1        9'h020
`define DSF_CLS_LVL2        9'h040
`define DSF_CLS_LVL3        9'h080

`endif

// File: logic/dsf_flag.sv
`timescale 1ns/10ps
// set/clear flag; a set in the same cycle as a clear wins
module dsf_flag #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // events
  input  wire logic set_i,
  input  wire logic clr_i,
  // flag
  output logic      q_o
);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= RST_VAL;
    end else begin
      q_o <= set_i | (q_o & ~clr_i);
    end
  end

endmodule : dsf_flag

// File: logic/dsf_pkg.sv
package dsf_pkg;

  typedef struct packed {
    logic bus_channel_enable;
    logic bus_dma_enable;
    logic host_dma_enable;
    logic direction;
    logic flush_request;
  } dsf_ctrl_t;

  typedef struct packed {
    logic transfer_all_done;
    logic host_side_done;
    logic scsi_side_done;
    logic bus_parity_error_flag;
    logic bus_enable_ack;
    logic bus_dma_enable_ack;
    logic host_dma_enable_ack;
    logic xfer_dir_ack;
    logic flush_ack;
    logic quad_word_empty;
    logic double_word_empty;
    logic memory_request_pending;
    logic fifo_at_capacity;
    logic fifo_drained;
    logic data_threshold_flag;
    logic cache_line_flag;
    logic fifo_companion_condition;
  } dsf_status_t;

endpackage : dsf_pkg

// File: logic/dsf_top.sv
//
// Contract
// - a flag may lag its control write by one sequencer instruction
// - scsi side done updates after counter load or wrap enable change
// - overall done updates after either counter load or wrap change
// - parity error sets only with check enabled; clear bit 2 clears it
// - each channel enable has its own acknowledge flag
// - direction ack follows direction only while all three enables are off
// - flush ack rises after flush request, gated by quad word empty
// - double word empty after fifo clear or a read leaving under 8 bytes
// - request pending sets on direction-dependent fill or drain events
// - request pending clears on opposite events, zero host count, clear
// - host done at zero count and last transfer; clears on nonzero load
// - threshold flag re-evaluated on every push or pop, data port or dma
// - full flag on a write reaching 256 bytes, or on fifo clear
// - empty flag on a read reaching 0 bytes, or on fifo clear
// - cache line flag takes the direction bit on clear, sets on free space or stored data events
// - cache line flag clears when space or data falls below line size
// - overall done is host done AND scsi side done
`timescale 1ns/10ps
`include "dsf_consts.svh"
module dsf_top (
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            nrst_i,
  // apb slave
  input  wire logic            psel_i,
  input  wire logic            penable_i,
  input  wire logic            pwrite_i,
  input  wire logic [7:0]      paddr_i,
  input  wire logic [31:0]     pwdata_i,
  output logic      [31:0]     prdata_o,
  output logic                 pready_o,
  output logic                 pslverr_o,
  // host dma master side
  input  wire logic            dma_push_i,
  input  wire logic [7:0]      dma_push_data_i,
  input  wire logic            dma_pop_i,
  output logic      [7:0]      dma_pop_data_o,
  output logic                 dma_hold_o,
  input  wire logic            dma_last_done_i,
  // bus side events
  input  wire logic            scsi_byte_i,
  input  wire logic            parity_err_i,
  // flags
  output dsf_pkg::dsf_status_t status_o
);
  import dsf_pkg::*;

  logic        rst_sync1, rst_sync2, rst_n;
  dsf_ctrl_t   ctrl;
  logic        cth_mode, parity_check_enable, counter_wrap_enable;
  logic [1:0]  thr_sel, cls_sel;
  logic [23:0] scsi_xfer_counter, host_byte_count;
  logic [7:0]  mem [0:255];
  logic [7:0]  wr_ptr, rd_ptr, push_data;
  logic [8:0]  level, next_level, thr_lvl, cls_lvl, next_free;
  logic        acc, commit, wr_ctrl, fifo_clear, push, pop, dma_push_ok, dma_pop_ok;
  logic        apb_push, apb_pop, mreq_set, mreq_clr, host_side_done_set, host_side_done_clr;
  logic        perr_set, perr_clr, flush_set, flush_clr, next_err;
  logic        next_full, next_empty, next_thr, next_cl, next_qwe, next_dwe, next_comp;
  logic        flag_full, flag_empty, flag_thr, flag_cl, flag_qwe, flag_dwe, flag_comp;
  logic        ack_bus, ack_bdma, ack_hdma, ack_dir;
  logic        scsi_done, all_done, host_done, perr, mreq, flush_ack;
  logic [31:0] next_rdata;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync1 <= 1'b0;
      rst_sync2 <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_sync2 <= rst_sync1;
    end
  end
  assign rst_n = rst_sync2;

  // apb: one wait state, effects happen at the edge where pready is seen high
  assign acc    = psel_i & penable_i;
  assign commit = acc & pready_o;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    unique case (paddr_i)
      `DSF_OFF_FIFO_CTRL:  next_rdata = {26'h0, ctrl, 1'b0};
      `DSF_OFF_XFER_CTRL1: begin
        next_rdata[`DSF_BIT_PCHK_EN] = parity_check_enable;
        next_rdata[`DSF_BIT_WRAP_EN] = counter_wrap_enable;
      end
      `DSF_OFF_INT_CLR1:   next_rdata = 32'h0000_0000;
      `DSF_OFF_CONFIG:     next_rdata = {27'h0, cth_mode, cls_sel, thr_sel};
      `DSF_OFF_SCSI_CNT:   next_rdata = {8'h00, scsi_xfer_counter};
      `DSF_OFF_HOST_CNT:   next_rdata = {8'h00, host_byte_count};
      `DSF_OFF_DATA_PORT: begin
        next_rdata = {24'h0, mem[rd_ptr]};
        next_err   = pwrite_i ? flag_full_lvl(level) : (level == 9'h000);
      end
      `DSF_OFF_STATUS:     next_rdata = {15'h0, status_o};
      `DSF_OFF_LEVEL:      next_rdata = {23'h0, level};
      default:             next_err = 1'b1;
    endcase
  end

  function automatic logic flag_full_lvl(input logic [8:0] lvl);
    flag_full_lvl = (lvl == `DSF_FIFO_DEPTH);
  endfunction : flag_full_lvl

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      dma_hold_o <= 1'b0;
    end else begin
      pready_o   <= acc & ~pready_o;
      pslverr_o  <= acc & ~pready_o & next_err;
      prdata_o   <= (acc & ~pready_o & ~pwrite_i) ? next_rdata : 32'h0000_0000;
      // keeps the dma master off the fifo during an apb data port commit
      dma_hold_o <= acc & ~pready_o & (paddr_i == `DSF_OFF_DATA_PORT);
    end
  end

  // control registers
  assign wr_ctrl    = commit & pwrite_i & (paddr_i == `DSF_OFF_FIFO_CTRL);
  assign fifo_clear = wr_ctrl & pwdata_i[`DSF_BIT_FIFO_CLEAR];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `DSF_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl <= pwdata_i[`DSF_BIT_BUS_EN:`DSF_BIT_FLUSH];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      {cth_mode, cls_sel, thr_sel} <= `DSF_RST_CONFIG;
    end else if (commit & pwrite_i & (paddr_i == `DSF_OFF_CONFIG)) begin
      cth_mode <= pwdata_i[`DSF_BIT_CTH_MODE];
      cls_sel  <= pwdata_i[`DSF_CLS_SEL_LSB +: 2];
      thr_sel  <= pwdata_i[`DSF_THR_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      parity_check_enable <= 1'b0;
      counter_wrap_enable <= 1'b0;
    end else if (commit & pwrite_i & (paddr_i == `DSF_OFF_XFER_CTRL1)) begin
      parity_check_enable <= pwdata_i[`DSF_BIT_PCHK_EN];
      counter_wrap_enable <= pwdata_i[`DSF_BIT_WRAP_EN];
    end
  end

  // transfer counters
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scsi_xfer_counter <= 24'h00_0000;
    end else if (commit & pwrite_i & (paddr_i == `DSF_OFF_SCSI_CNT)) begin
      scsi_xfer_counter <= pwdata_i[23:0];
    end else if (scsi_byte_i & (ctrl.bus_dma_enable | ctrl.bus_channel_enable)
                 & ((scsi_xfer_counter != 24'h00_0000) | counter_wrap_enable)) begin
      scsi_xfer_counter <= scsi_xfer_counter - 24'h00_0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      host_byte_count <= 24'h00_0000;
    end else if (commit & pwrite_i & (paddr_i == `DSF_OFF_HOST_CNT)) begin
      host_byte_count <= pwdata_i[23:0];
    end else if (((ctrl.direction & dma_push_ok) | (~ctrl.direction & dma_pop_ok))
                 & (host_byte_count != 24'h00_0000)) begin
      host_byte_count <= host_byte_count - 24'h00_0001;
    end
  end

  // fifo storage and level
  assign apb_push    = commit & pwrite_i & (paddr_i == `DSF_OFF_DATA_PORT) & ~flag_full_lvl(level);
  assign apb_pop     = commit & ~pwrite_i & (paddr_i == `DSF_OFF_DATA_PORT) & (level != 9'h000);
  assign dma_push_ok = dma_push_i & ~dma_hold_o & ~flag_full_lvl(level);
  assign dma_pop_ok  = dma_pop_i & ~dma_hold_o & (level != 9'h000);
  assign push        = (apb_push | dma_push_ok) & ~fifo_clear;
  assign pop         = (apb_pop | dma_pop_ok) & ~fifo_clear;
  assign push_data   = apb_push ? pwdata_i[7:0] : dma_push_data_i;

  always_comb begin
    next_level = level;
    if (fifo_clear) begin
      next_level = 9'h000;
    end else if (push & ~pop) begin
      next_level = level + 9'h001;
    end else if (pop & ~push) begin
      next_level = level - 9'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr         <= 8'h00;
      rd_ptr         <= 8'h00;
      level          <= 9'h000;
      dma_pop_data_o <= 8'h00;
    end else begin
      level <= next_level;
      if (fifo_clear) begin
        wr_ptr <= 8'h00;
        rd_ptr <= 8'h00;
      end else begin
        wr_ptr <= wr_ptr + {7'h00, push};
        rd_ptr <= rd_ptr + {7'h00, pop};
      end
      if (dma_pop_ok & ~fifo_clear) begin
        dma_pop_data_o <= mem[rd_ptr];
      end
    end
  end

  // level flags: each moves only on a push, a pop (data port or dma) or a clear
  always_comb begin
    unique case (thr_sel)
      2'h0: thr_lvl = `DSF_THR_LVL0;
      2'h1: thr_lvl = `DSF_THR_LVL1;
      2'h2: thr_lvl = `DSF_THR_LVL2;
      2'h3: thr_lvl = `DSF_THR_LVL3;
    endcase
    unique case (cls_sel)
      2'h0: cls_lvl = `DSF_CLS_LVL0;
      2'h1: cls_lvl = `DSF_CLS_LVL1;
      2'h2: cls_lvl = `DSF_CLS_LVL2;
      2'h3: cls_lvl = `DSF_CLS_LVL3;
    endcase
    next_free  = `DSF_FIFO_DEPTH - next_level;
    next_full  = flag_full;
    next_empty = flag_empty;
    next_thr   = flag_thr;
    next_cl    = flag_cl;
    next_dwe   = flag_dwe;
    next_qwe   = flag_qwe;
    next_comp  = flag_comp;
    if (fifo_clear) begin
      next_full  = 1'b1;
      next_empty = 1'b1;
      next_dwe   = 1'b1;
      next_qwe   = 1'b1;
      next_thr   = 1'b0;
      next_cl    = ctrl.direction;
      next_comp  = 1'b0;
    end else if (push | pop) begin
      next_full  = (next_level == `DSF_FIFO_DEPTH);
      next_empty = (next_level == 9'h000);
      next_thr   = (next_level >= thr_lvl);
      next_dwe   = (next_level < `DSF_DWORD_EMPTY_LVL);
      next_qwe   = (next_level < `DSF_QWORD_EMPTY_LVL);
      next_comp  = (next_free < cls_lvl);
      if (ctrl.direction) begin
        next_cl = (next_free >= cls_lvl);
      end else begin
        next_cl = (next_level >= cls_lvl);
      end
    end
  end

  // chip reset leaves the flags as a fifo clear would
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flag_full  <= 1'b1;
      flag_empty <= 1'b1;
      flag_thr   <= 1'b0;
      flag_cl    <= 1'b0;
      flag_dwe   <= 1'b1;
      flag_qwe   <= 1'b1;
      flag_comp  <= 1'b0;
    end else begin
      flag_full  <= next_full;
      flag_empty <= next_empty;
      flag_thr   <= next_thr;
      flag_cl    <= next_cl;
      flag_dwe   <= next_dwe;
      flag_qwe   <= next_qwe;
      flag_comp  <= next_comp;
    end
  end

  // acknowledges sample the control register, so they trail the write by a clock
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_bus  <= 1'b0;
      ack_bdma <= 1'b0;
      ack_hdma <= 1'b0;
      ack_dir  <= 1'b0;
    end else begin
      ack_bus  <= ctrl.bus_channel_enable;
      ack_bdma <= ctrl.bus_dma_enable;
      ack_hdma <= ctrl.host_dma_enable;
      if (~ctrl.bus_channel_enable & ~ctrl.bus_dma_enable & ~ctrl.host_dma_enable) begin
        ack_dir <= ctrl.direction;
      end
    end
  end

  // done flags; counter state is registered first, so a load shows one clock later in scsi done and two clocks later in overall done
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scsi_done <= 1'b0;
      all_done  <= 1'b0;
    end else begin
      scsi_done <= (scsi_xfer_counter == 24'h00_0000) & ~counter_wrap_enable;
      all_done  <= host_done & scsi_done;
    end
  end

  assign host_side_done_set = (host_byte_count == 24'h00_0000) & dma_last_done_i;
  assign host_side_done_clr = commit & pwrite_i & (paddr_i == `DSF_OFF_HOST_CNT)
                     & (pwdata_i[23:0] != 24'h00_0000);

  assign perr_set  = parity_check_enable & parity_err_i;
  assign perr_clr  = commit & pwrite_i & (paddr_i == `DSF_OFF_INT_CLR1)
                     & pwdata_i[`DSF_BIT_PERR_CLR];

  // flush completes once the fifo has drained to the quad word mark
  assign flush_set = ctrl.flush_request & flag_qwe & ~fifo_clear;
  assign flush_clr = ~ctrl.flush_request | fifo_clear;

  // request pending: set terms are rising edges of registered level flags, plus a new flush request write while direction is 0
  assign mreq_set = ctrl.host_dma_enable & ~fifo_clear & (
                      (ctrl.direction & next_qwe & ~flag_qwe)
                    | (~ctrl.direction & ((next_full & ~flag_full)
                       | (wr_ctrl & pwdata_i[`DSF_BIT_FLUSH] & ~ctrl.flush_request)))
                    | (~cth_mode & next_thr & ~flag_thr)
                    | (cth_mode & next_cl & ~flag_cl));
  assign mreq_clr = ~ctrl.host_dma_enable | fifo_clear
                  | (host_byte_count == 24'h00_0000)
                  | (ctrl.direction & ((next_full & ~flag_full) | (next_comp & ~flag_comp)))
                  | (~ctrl.direction & next_qwe & ~flag_qwe);

  dsf_flag u_host_done (
    .clk_i (clk_i), .rst_n_i (rst_n), .set_i (host_side_done_set), .clr_i (host_side_done_clr), .q_o (host_done)
  );
  dsf_flag u_parity (
    .clk_i (clk_i), .rst_n_i (rst_n), .set_i (perr_set), .clr_i (perr_clr), .q_o (perr)
  );
  dsf_flag u_flush_ack (
    .clk_i (clk_i), .rst_n_i (rst_n), .set_i (flush_set), .clr_i (flush_clr), .q_o (flush_ack)
  );
  dsf_flag u_mreq (
    .clk_i (clk_i), .rst_n_i (rst_n), .set_i (mreq_set), .clr_i (mreq_clr), .q_o (mreq)
  );

  assign status_o = '{transfer_all_done: all_done, host_side_done: host_done,
    scsi_side_done: scsi_done, bus_parity_error_flag: perr, bus_enable_ack: ack_bus,
    bus_dma_enable_ack: ack_bdma, host_dma_enable_ack: ack_hdma, xfer_dir_ack: ack_dir,
    flush_ack: flush_ack, quad_word_empty: flag_qwe, double_word_empty: flag_dwe,
    memory_request_pending: mreq, fifo_at_capacity: flag_full, fifo_drained: flag_empty,
    data_threshold_flag: flag_thr, cache_line_flag: flag_cl,
    fifo_companion_condition: flag_comp};

endmodule : dsf_top
